// ==== gcm_clock_mux.sv ====
// Glitchless 2:1 clock switchover mux, sampled on clk.
// Assumes both input clocks and the select are far slower than clk and
// asynchronous to it; arst_n stands for the power-on reset.
`timescale 1ns/1ps
`include "gcm_consts.svh"

// What this block does
// - On a select change with healthy clocks the old clock is still passed for a few pulses.
// - Then the output stays low for a few target-clock pulses before it follows the target.
// - If the old clock is stuck high, the output stays high for a few target pulses.
// - After that high hold the output goes low for a few target falling edges, then follows.
// - The stretched cycle of a stuck-high switch is over half a target period in each phase.
// - If the old clock is stuck low, the output stays low a few target falls, then follows.
// - A decayed old clock is handled as stuck high or low by its last valid level.
// - A selected clock that stops leaves the output at a steady level with no toggling.
// - A slowly degrading but toggling clock is passed as is, without runt suppression.
// - The select is synchronised, so stage counts may vary by a pulse or so.
// - Reset forces the sequencer into a known state until it is released.
// - With the delay capacitor pin tied high the mux switches at once, unprotected.
// - With protection on, the output follows the new clock within 17 of its cycles.
module gcm_clock_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Clock inputs and controls
  input wire logic clock_input_a,
  input wire logic clock_input_b,
  input wire logic select_in,
  input wire logic delay_capacitor_pin,
  // Outputs
  output logic clock_out,
  output logic selected_b,
  output logic switching
);

  gcm_sync_if sync_bus ();
  gcm_pkg::gcm_state_t st_r;
  logic cur_sel_r;
  logic out_r;
  logic a_prev_r;
  logic b_prev_r;
  logic [`GCM_CNT_W-1:0] old_cnt_r;
  logic [`GCM_CNT_W-1:0] tgt_cnt_r;
  logic sel_f;
  logic a_f;
  logic b_f;
  logic bypass;
  logic old_lvl;
  logic tgt_lvl;
  logic old_fall;
  logic tgt_fall;
  logic stuck;
  logic high_done;
  logic low_done;
  logic a_fall;
  logic b_fall;
  logic switching_r;

  assign sync_bus.raw = {delay_capacitor_pin, clock_input_b, clock_input_a, select_in};

  gcm_sync3 gcm_sync3_i (
    .clk(clk),
    .arst_n(arst_n),
    .port(sync_bus.sync)
  );

  assign sel_f = sync_bus.clean[`GCM_BIT_SEL];
  assign a_f = sync_bus.clean[`GCM_BIT_A];
  assign b_f = sync_bus.clean[`GCM_BIT_B];
  assign bypass = sync_bus.clean[`GCM_BIT_BYP];

  // Previous levels for edge detection of both clocks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_prev_r <= a_f;
      b_prev_r <= b_f;
    end
  end

  assign a_fall = a_prev_r & ~a_f;
  assign b_fall = b_prev_r & ~b_f;

  // old and target roles follow the current choice
  assign old_lvl = cur_sel_r ? b_f : a_f;
  assign tgt_lvl = cur_sel_r ? a_f : b_f;
  assign old_fall = cur_sel_r ? b_fall : a_fall;
  assign tgt_fall = cur_sel_r ? a_fall : b_fall;
  assign stuck = tgt_fall && !old_fall && (tgt_cnt_r == `GCM_STUCK_LAST);
  assign high_done = tgt_fall && (tgt_cnt_r == `GCM_HIGH_LAST);
  assign low_done = tgt_fall && (tgt_cnt_r == `GCM_LOW_LAST);

  // Sequencer state and the current choice of input
  // known state at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= gcm_pkg::GCM_PASS;
      cur_sel_r <= 1'b0;
    end else if (bypass) begin
      st_r <= gcm_pkg::GCM_PASS;
      cur_sel_r <= sel_f;
    end else begin
      case (st_r)
        gcm_pkg::GCM_PASS: begin
          if (sel_f != cur_sel_r) begin
            st_r <= gcm_pkg::GCM_DRAIN;
          end
        end
        gcm_pkg::GCM_DRAIN: begin
          if (old_fall && (old_cnt_r == `GCM_OLD_LAST)) begin
            st_r <= gcm_pkg::GCM_HOLD_LOW;
          end else if (stuck) begin
            st_r <= out_r ? gcm_pkg::GCM_HOLD_HIGH : gcm_pkg::GCM_HOLD_LOW;
          end
        end
        gcm_pkg::GCM_HOLD_HIGH: begin
          if (high_done) begin
            st_r <= gcm_pkg::GCM_HOLD_LOW;
          end
        end
        gcm_pkg::GCM_HOLD_LOW: begin
          // Hand over on a target fall, so the first passed level is low
          if (low_done) begin
            st_r <= gcm_pkg::GCM_PASS;
            cur_sel_r <= ~cur_sel_r;
          end
        end
        default: begin
          st_r <= gcm_pkg::GCM_PASS;
        end
      endcase
    end
  end

  // per-clock stage counters, stepped on edges only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      old_cnt_r <= `GCM_CNT_ZERO;
      tgt_cnt_r <= `GCM_CNT_ZERO;
    end else if (bypass || st_r == gcm_pkg::GCM_PASS) begin
      old_cnt_r <= `GCM_CNT_ZERO;
      tgt_cnt_r <= `GCM_CNT_ZERO;
    end else if (st_r == gcm_pkg::GCM_DRAIN) begin
      if (old_fall) begin
        // A live old clock restarts the stuck watch
        old_cnt_r <= old_cnt_r + `GCM_CNT_ONE;
        tgt_cnt_r <= `GCM_CNT_ZERO;
      end else if (stuck) begin
        tgt_cnt_r <= `GCM_CNT_ZERO;
      end else if (tgt_fall) begin
        tgt_cnt_r <= tgt_cnt_r + `GCM_CNT_ONE;
      end
    end else if (high_done) begin
      tgt_cnt_r <= `GCM_CNT_ZERO;
    end else if (tgt_fall) begin
      tgt_cnt_r <= tgt_cnt_r + `GCM_CNT_ONE;
    end
  end

  // Output level; the sampled clock is registered, so a stopped input holds it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= 1'b0;
    end else if (bypass) begin
      out_r <= sel_f ? b_f : a_f;
    end else begin
      case (st_r)
        // plain pass of the selected level
        gcm_pkg::GCM_PASS: out_r <= old_lvl;
        gcm_pkg::GCM_DRAIN: begin
          if (old_fall && (old_cnt_r == `GCM_OLD_LAST)) begin
            out_r <= 1'b0;
          end else if (!stuck) begin
            out_r <= old_lvl;
          end
        end
        // high hold, stretched over two target falls
        gcm_pkg::GCM_HOLD_HIGH: out_r <= ~high_done;
        // low hold, target level on hand-over
        gcm_pkg::GCM_HOLD_LOW: out_r <= low_done ? tgt_lvl : 1'b0;
        default: out_r <= 1'b0;
      endcase
    end
  end

  assign clock_out = out_r;
  assign selected_b = cur_sel_r;
  assign switching = switching_r;

  // Busy flag from a flop, one cycle behind the state; a decode could glitch on the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      switching_r <= 1'b0;
    end else begin
      switching_r <= (st_r != gcm_pkg::GCM_PASS);
    end
  end

  // Checks: target falls spent in one switchover
  logic [`GCM_SEQ_W-1:0] seq_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_r <= `GCM_SEQ_ZERO;
    end else if (st_r == gcm_pkg::GCM_PASS) begin
      seq_r <= `GCM_SEQ_ZERO;
    end else if (tgt_fall && seq_r != `GCM_MAX_SWITCH + `GCM_SEQ_ONE) begin
      seq_r <= seq_r + `GCM_SEQ_ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_drain_follows;
    (st_r == gcm_pkg::GCM_DRAIN && !bypass && !old_fall && !stuck) |=>
      (out_r == $past(old_lvl));
  endproperty
  a_drain_follows: assert property (p_drain_follows) else $error("old clock not passed");

  property p_low_hold;
    (st_r == gcm_pkg::GCM_HOLD_LOW && !bypass) |=> !out_r;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low hold broken");

  property p_high_hold;
    (st_r == gcm_pkg::GCM_HOLD_HIGH && !bypass && !high_done) |=> out_r;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high hold broken");

  property p_high_to_low;
    (st_r == gcm_pkg::GCM_HOLD_HIGH && !bypass ##1 st_r == gcm_pkg::GCM_HOLD_LOW) |-> !out_r;
  endproperty
  a_high_to_low: assert property (p_high_to_low) else $error("no drop after high hold");

  property p_stretch;
    (st_r == gcm_pkg::GCM_HOLD_LOW && $past(st_r) == gcm_pkg::GCM_HOLD_HIGH) |->
      ($past(tgt_cnt_r) == `GCM_HIGH_LAST);
  endproperty
  a_stretch: assert property (p_stretch) else $error("high phase too short");

  property p_stuck_low;
    (st_r == gcm_pkg::GCM_DRAIN && !bypass && stuck && !out_r) |=>
      (st_r == gcm_pkg::GCM_HOLD_LOW);
  endproperty
  a_stuck_low: assert property (p_stuck_low) else $error("stuck low path not taken");

  property p_stuck_high;
    (st_r == gcm_pkg::GCM_DRAIN && !bypass && stuck && out_r) |=>
      (st_r == gcm_pkg::GCM_HOLD_HIGH && out_r);
  endproperty
  a_stuck_high: assert property (p_stuck_high) else $error("stuck high path not taken");

  property p_steady;
    (st_r == gcm_pkg::GCM_PASS && !bypass && $past(st_r) == gcm_pkg::GCM_PASS &&
      $stable(cur_sel_r) && $stable(old_lvl)) |=> $stable(out_r);
  endproperty
  a_steady: assert property (p_steady) else $error("output moved on a still clock");

  property p_bypass;
    (bypass && sel_f != cur_sel_r) |=> (cur_sel_r == $past(sel_f) && st_r == gcm_pkg::GCM_PASS);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not switch at once");

  property p_bound;
    seq_r <= `GCM_MAX_SWITCH;
  endproperty
  a_bound: assert property (p_bound) else $error("switchover too long");

  c_healthy: cover property (st_r == gcm_pkg::GCM_DRAIN ##1 st_r == gcm_pkg::GCM_HOLD_LOW
    ##[1:200] st_r == gcm_pkg::GCM_PASS);
  c_stuck_high: cover property (st_r == gcm_pkg::GCM_HOLD_HIGH ##[1:200]
    st_r == gcm_pkg::GCM_HOLD_LOW);
  c_bypass: cover property (bypass && sel_f != cur_sel_r);

endmodule

// ==== gcm_consts.svh ====
// Named constants for the glitchless clock switchover mux.
// Included by the package user files; holds definitions only.
`ifndef GCM_CONSTS_SVH
`define GCM_CONSTS_SVH

// Bit positions inside the synchroniser vector
`define GCM_SYNC_W 4
`define GCM_BIT_SEL 0
`define GCM_BIT_A 1
`define GCM_BIT_B 2
`define GCM_BIT_BYP 3

// Stage counters, counted in edges of one input clock
`define GCM_CNT_W 3
`define GCM_CNT_ZERO 3'h0
`define GCM_CNT_ONE 3'h1
// Last count of old-clock pulses still passed (two pulses)
`define GCM_OLD_LAST 3'h1
// Last target falling edge with no old edge before the old clock is taken as stuck
`define GCM_STUCK_LAST 3'h2
// Last target falling edge of the high hold (two pulses)
`define GCM_HIGH_LAST 3'h1
// Last target falling edge of the low hold (two edges)
`define GCM_LOW_LAST 3'h1

// Whole switchover bound, in target-clock cycles
`define GCM_SEQ_W 5
`define GCM_SEQ_ZERO 5'h00
`define GCM_SEQ_ONE 5'h01
`define GCM_MAX_SWITCH 5'h11

// Synchroniser reset value
`define GCM_SYNC_RST 4'h0

`endif

// ==== gcm_pkg.sv ====
// Types shared by the glitchless clock switchover mux files.
// Assumes nothing of its surroundings.
package gcm_pkg;

  // Switchover sequencer states
  typedef enum logic [1:0] {
    GCM_PASS,
    GCM_DRAIN,
    GCM_HOLD_HIGH,
    GCM_HOLD_LOW
  } gcm_state_t;

endpackage

// ==== gcm_sync_if.sv ====
// Carrier between the top and its input synchroniser.
// Assumes both ends run on the same clk.
`timescale 1ns/1ps
`include "gcm_consts.svh"

interface gcm_sync_if;
  logic [`GCM_SYNC_W-1:0] raw;
  logic [`GCM_SYNC_W-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ==== gcm_sync3.sv ====
// Three-flop synchroniser with agreement filter for asynchronous pins.
// Assumes raw inputs are asynchronous to clk and change slower than clk.
`timescale 1ns/1ps
`include "gcm_consts.svh"

module gcm_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Pins in, filtered levels out
  gcm_sync_if.sync port
);

  logic [`GCM_SYNC_W-1:0] s1_r;
  logic [`GCM_SYNC_W-1:0] s2_r;
  logic [`GCM_SYNC_W-1:0] s3_r;
  logic [`GCM_SYNC_W-1:0] clean_r;

  // Flop chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= `GCM_SYNC_RST;
      s2_r <= `GCM_SYNC_RST;
      s3_r <= `GCM_SYNC_RST;
    end else begin
      s1_r <= port.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit only changes once stages two and three agree, filtering a late settle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clean_r <= `GCM_SYNC_RST;
    end else begin
      for (int i = 0; i < `GCM_SYNC_W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign port.clean = clean_r;

endmodule

// ==== gcm_src_model.sv ====
// Partner model: two input clock sources that can each be stopped.
// Assumes clk is the bench sampling clock; half periods count clk cycles.
`timescale 1ns/1ps

module gcm_src_model (
  // Sampling clock
  input wire logic clk,
  // Source controls
  input wire logic [7:0] half_a,
  input wire logic [7:0] half_b,
  input wire logic run_a,
  input wire logic run_b,
  // Clocks to the mux
  output logic clock_input_a,
  output logic clock_input_b
);
  logic [7:0] cnt_a = 8'h00;
  logic [7:0] cnt_b = 8'h05;

  // Sources start low, out of phase with each other
  initial begin
    clock_input_a = 1'b0;
    clock_input_b = 1'b0;
  end

  // ratio set by caller
  // A stopped source freezes at its level, like a dead oscillator
  always @(negedge clk) begin
    if (run_a) begin
      cnt_a <= (cnt_a + 8'h01 >= half_a) ? 8'h00 : cnt_a + 8'h01;
      if (cnt_a + 8'h01 >= half_a) clock_input_a <= ~clock_input_a;
    end
  end

  always @(negedge clk) begin
    if (run_b) begin
      cnt_b <= (cnt_b + 8'h01 >= half_b) ? 8'h00 : cnt_b + 8'h01;
      if (cnt_b + 8'h01 >= half_b) clock_input_b <= ~clock_input_b;
    end
  end
endmodule

// ==== test_gcm_clock_mux.sv ====
// Self-checking bench for the glitchless clock switchover mux.
// Assumes gcm_src_model drives both clocks; inputs change at falling edges.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module test_gcm_clock_mux;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic select_in = 1'b0;
  logic delay_capacitor_pin = 1'b0;
  logic run_a = 1'b1;
  logic run_b = 1'b1;
  logic [7:0] half_a = 8'h0a;
  logic [7:0] half_b = 8'h0a;
  logic clock_input_a, clock_input_b, clock_out, selected_b, switching;
  logic notes[$];
  logic sel_seen = 1'b0;
  logic last_out = 1'b0;
  logic exp_sel;
  logic runt_on = 1'b0;
  integer seed = 32'h8313;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int run_len = 0;
  int lo_max = 0;
  int waited = 0;

  always #50 clk = ~clk;

  gcm_src_model gcm_src_model_i (.clk(clk), .half_a(half_a), .half_b(half_b),
    .run_a(run_a), .run_b(run_b), .clock_input_a(clock_input_a),
    .clock_input_b(clock_input_b));

  gcm_clock_mux gcm_clock_mux_i (.clk(clk), .arst_n(arst_n),
    .clock_input_a(clock_input_a), .clock_input_b(clock_input_b),
    .select_in(select_in), .delay_capacitor_pin(delay_capacitor_pin),
    .clock_out(clock_out), .selected_b(selected_b), .switching(switching));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Each settled selection is matched against the oldest note
  always @(negedge clk) begin
    if (selected_b !== sel_seen) begin
      exp_sel = (notes.size() > 0) ? notes.pop_front() : sel_seen;
      `CHK(selected_b, exp_sel)
    end
    sel_seen = selected_b;
  end

  // Phase lengths of the output; a short one would be a runt pulse
  always @(negedge clk) begin
    cycles++;
    if (clock_out === last_out) run_len++;
    else begin
      if (runt_on) `CHK(run_len >= 8, 1'b1)
      if (!last_out && run_len > lo_max) lo_max = run_len;
      run_len = 1;
    end
    last_out = clock_out;
    if (cycles > 40000) begin
      n_fail++;
      results();
    end
  end

  // Modes: 0 healthy, 1 old stuck high, 2 old stuck low, 3 bypass
  task automatic do_switch(input logic want, input int mode);
    int n;
    int mv;
    int h;
    logic prev;
    logic saw;
    n = 0;
    mv = 0;
    saw = 1'b0;
    h = want ? half_b : half_a;
    repeat ($unsigned($random(seed)) % 30) @(negedge clk);
    lo_max = 0;
    select_in = want;
    notes.push_back(want);
    prev = clock_out;
    while (selected_b !== want && n < 40 * h) begin
      @(negedge clk);
      n++;
      saw |= switching;
      if (clock_out !== prev) mv++;
      prev = clock_out;
    end
    if (mode == 3) begin
      `CHK(n <= 8, 1'b1)
      `CHK(saw, 1'b0)
    end else begin
      `CHK(n <= 34 * h + 10, 1'b1)
      `CHK(saw, 1'b1)
    end
    repeat (3 * h + 6) @(negedge clk);
    if (mode == 0) `CHK(mv >= 2, 1'b1)
    if (mode == 0) `CHK(lo_max >= 2 * h - 2, 1'b1)
    if (mode == 1) `CHK(mv, 1)
    if (mode == 1) `CHK(lo_max >= 2 * h - 2, 1'b1)
    if (mode == 2) `CHK(mv, 0)
    $display("test switch to %0d mode %0d done", want, mode);
  endtask

  // Freeze source a at a level; the output must settle and stay there
  // Stop just after a fresh edge to lvl, so the source cannot toggle in that same step
  task automatic stop_a(input logic lvl);
    int mv;
    mv = 0;
    while (clock_input_a === lvl) @(negedge clk);
    while (clock_input_a !== lvl) @(negedge clk);
    run_a = 1'b0;
    repeat (20) @(negedge clk);
    repeat (150) begin
      @(negedge clk);
      if (clock_out !== lvl) mv++;
    end
    `CHK(clock_out, lvl)
    `CHK(mv, 0)
    $display("test stop a at %0d done", lvl);
  endtask

  initial begin
    half_a = 8'h0a + 8'($unsigned($random(seed)) % 4);
    half_b = 8'h0a + 8'($unsigned($random(seed)) % 4);
    repeat (5) @(negedge clk);
    `CHK({clock_out, selected_b, switching}, 3'h0)
    $display("test power-up reset done");
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (40) @(negedge clk);
    runt_on = 1'b1;
    repeat (3) begin
      do_switch(1'b1, 0);
      do_switch(1'b0, 0);
    end
    stop_a(1'b1);
    do_switch(1'b1, 1);
    run_a = 1'b1;
    do_switch(1'b0, 0);
    stop_a(1'b0);
    do_switch(1'b1, 2);
    run_a = 1'b1;
    do_switch(1'b0, 0);
    // Bypass may cut phases short, so the runt watch is off for the rest of the run
    runt_on = 1'b0;
    delay_capacitor_pin = 1'b1;
    repeat (10) @(negedge clk);
    do_switch(1'b1, 3);
    do_switch(1'b0, 3);
    do_switch(1'b1, 3);
    delay_capacitor_pin = 1'b0;
    repeat (60) @(negedge clk);
    notes.push_back(1'b0);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({clock_out, selected_b, switching}, 3'h0)
    arst_n = 1'b1;
    // Select still asks for b, so a protected switch must start from the reset choice
    notes.push_back(1'b1);
    while (selected_b !== 1'b1 && waited < 40 * half_b) begin
      @(negedge clk);
      waited++;
    end
    repeat (20) @(negedge clk);
    `CHK(selected_b, 1'b1)
    `CHK(notes.size(), 0)
    $display("test reset done");
    results();
  end
endmodule
